// ### inc/ppfm_pkg.sv
// Package for the parallel port and flag pin multiplexer.
// Assumes a single core clock domain and synchronous reset.
package ppfm_pkg;
  localparam int SC_W = 32;
  localparam int SC_PP_DIS = 20;
  localparam int SC_FLG_GRP0 = 22;
  localparam int SC_PWM_GRP0 = 26;
  localparam int SC_IRQ0 = 16;
  localparam int SC_TIMER_EXPIRED_OUTPUT = 19;
  localparam logic [31:0] SC_RST = 32'h0000_0000;
  localparam logic ALE_POL_RST = 1'b1;
  localparam int NGRP = 4;
  typedef enum logic [1:0] {
    PP_IDLE = 2'b00,
    PP_ALE = 2'b01,
    PP_DATA = 2'b11,
    PP_DONE = 2'b10
  } ppfm_state_t;
endpackage

// ### rtl/ppfm_grp.sv
// One group of four address/data pins: selects flag, pwm or port use.
// Assumes the parent decides the parallel port function when neither is on.
`timescale 1ns/1ps
module ppfm_grp (
  input wire logic flg_en_in,
  input wire logic pwm_en_in,
  input wire logic [3:0] port_o_in,
  input wire logic [3:0] port_oe_in,
  input wire logic [3:0] flg_o_in,
  input wire logic [3:0] flg_oe_in,
  input wire logic [3:0] pwm_in,
  output logic [3:0] o_out,
  output logic [3:0] oe_out
);
  always_comb begin
    if (pwm_en_in) begin // [RULE7]
      o_out = pwm_in;
      oe_out = 4'hf;
    end else if (flg_en_in) begin // [RULE6]
      o_out = flg_o_in;
      oe_out = flg_oe_in;
    end else begin
      o_out = port_o_in;
      oe_out = port_oe_in;
    end
  end
endmodule

// ### rtl/ppfm_top.sv
// Parallel port pin sequencer with flag, pwm and input data port sharing.
// Assumes a core that issues one access at a time and keeps it held.
// Operation
// (RULE1) Address and data time-share pins, strobe marks phase
// (RULE2) Eight or sixteen bit bus width
// (RULE3) Eight-bit: strobe when upper address changes
// (RULE4) Sixteen-bit: strobe when low address changes
// (RULE5) Control bit 20 disables the parallel port
// (RULE6) Bits 22-25 enable flag groups of four
// (RULE7) Bits 26-29 enable pwm groups of four
// (RULE8) Input data port channel 0 samples pins
// (RULE9) Read strobe low during external reads
// (RULE10) Write strobe low during external writes
// (RULE11) Flag use holds all strobes deasserted
// (RULE12) Latch strobe active high, software may invert
// (RULE13) Flag pins individually input or output
// (RULE14) Flag pins serve as SPI slave selects
// (RULE15) Boot drives first flag as slave select
// (RULE16) Bits 16-18 make flags 0-2 interrupt inputs
// (RULE17) Bit 19 makes flag 3 timer output
// (RULE18) Control word applies next cycle, persists
`timescale 1ns/1ps
module ppfm_top #(
  parameter int AW = 24
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic sc_we_in,
  input wire logic [31:0] sc_wdata_in,
  input wire logic ale_act_low_in,
  input wire logic mode16_in,
  input wire logic req_in,
  input wire logic req_wr_in,
  input wire logic [AW-1:0] req_addr_in,
  input wire logic [15:0] req_wdata_in,
  input wire logic [15:0] ad_in,
  input wire logic [15:0] pflag_o_in,
  input wire logic [15:0] pflag_oe_in,
  input wire logic [15:0] pwm_in,
  input wire logic [3:0] gflag_in,
  input wire logic [3:0] gflag_o_in,
  input wire logic [3:0] gflag_oe_in,
  input wire logic [3:0] spi_ss_en_in,
  input wire logic [3:0] spi_ss_n_in,
  input wire logic spi_boot_in,
  input wire logic timer_exp_in,
  output logic [31:0] sc_out,
  output logic [15:0] ad_out,
  output logic [15:0] ad_oe_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic ale_out,
  output logic ack_out,
  output logic [15:0] rdata_out,
  output logic [15:0] idp0_data_out,
  output logic [15:0] pflag_in_out,
  output logic [3:0] gflag_o_out,
  output logic [3:0] gflag_oe_out,
  output logic [3:0] gflag_cond_out,
  output logic [2:0] irq_out
);
  typedef struct packed {
    logic [31:0] sc;
    ppfm_pkg::ppfm_state_t st;
    logic [AW-1:0] last_addr;
    logic addr_vld;
    logic [15:0] ad;
    logic [15:0] ad_oe;
    logic rd_n;
    logic wr_n;
    logic ale;
    logic ack;
    logic [15:0] rdata;
    logic [15:0] idp0;
    logic [15:0] pflag_in;
    logic [3:0] g_o;
    logic [3:0] g_oe;
    logic [3:0] g_cond;
    logic [2:0] irq;
  } ppfm_regs_t;

  ppfm_regs_t cur_ff;
  ppfm_regs_t nxt_ff;
  logic [15:0] mux_o;
  logic [15:0] mux_oe;
  logic pp_dis;
  logic any_flag;
  logic need_ale;

  assign pp_dis = cur_ff.sc[ppfm_pkg::SC_PP_DIS];
  assign any_flag = |cur_ff.sc[ppfm_pkg::SC_FLG_GRP0 +: ppfm_pkg::NGRP];

  // Upper bits in 8-bit mode, low 16 in 16-bit mode
  always_comb begin
    if (!cur_ff.addr_vld) begin
      need_ale = 1'b1;
    end else if (mode16_in) begin // [RULE4] [RULE2]
      need_ale = req_addr_in[15:0] != cur_ff.last_addr[15:0];
    end else begin // [RULE3]
      need_ale = req_addr_in[AW-1:8] != cur_ff.last_addr[AW-1:8];
    end
  end

  for (genvar g = 0; g < ppfm_pkg::NGRP; g++) begin : g_grp
    ppfm_grp u_grp (
      .flg_en_in(nxt_ff.sc[ppfm_pkg::SC_FLG_GRP0 + g]),
      .pwm_en_in(nxt_ff.sc[ppfm_pkg::SC_PWM_GRP0 + g]),
      .port_o_in(nxt_ff.ad[4*g +: 4]),
      .port_oe_in(nxt_ff.ad_oe[4*g +: 4]),
      .flg_o_in(pflag_o_in[4*g +: 4]),
      .flg_oe_in(pflag_oe_in[4*g +: 4]),
      .pwm_in(pwm_in[4*g +: 4]),
      .o_out(mux_o[4*g +: 4]),
      .oe_out(mux_oe[4*g +: 4])
    );
  end

  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.ack = 1'b0;
    if (sc_we_in) begin
      nxt_ff.sc = sc_wdata_in; // [RULE18]
    end
    nxt_ff.idp0 = ad_in; // [RULE8]
    nxt_ff.pflag_in = ad_in;
    nxt_ff.g_cond = gflag_in; // [RULE13]
    nxt_ff.irq = gflag_in[2:0] & cur_ff.sc[ppfm_pkg::SC_IRQ0 +: 3]; // [RULE16]
    for (int i = 0; i < 4; i++) begin
      if (spi_ss_en_in[i]) begin // [RULE14]
        nxt_ff.g_o[i] = spi_ss_n_in[i];
        nxt_ff.g_oe[i] = 1'b1;
      end else begin // [RULE13]
        nxt_ff.g_o[i] = gflag_o_in[i];
        nxt_ff.g_oe[i] = gflag_oe_in[i];
      end
    end
    if (spi_boot_in) begin // [RULE15]
      nxt_ff.g_o[0] = spi_ss_n_in[0];
      nxt_ff.g_oe[0] = 1'b1;
    end
    if (cur_ff.sc[ppfm_pkg::SC_TIMER_EXPIRED_OUTPUT]) begin // [RULE17]
      nxt_ff.g_o[3] = timer_exp_in;
      nxt_ff.g_oe[3] = 1'b1;
    end
    for (int i = 0; i < 3; i++) begin
      if (cur_ff.sc[ppfm_pkg::SC_IRQ0 + i]) begin
        nxt_ff.g_oe[i] = 1'b0;
      end
    end
    unique case (cur_ff.st)
      ppfm_pkg::PP_IDLE: begin
        nxt_ff.ad_oe = 16'h0000;
        if (req_in && !pp_dis && !any_flag) begin
          if (need_ale) begin // [RULE1] [RULE12]
            nxt_ff.st = ppfm_pkg::PP_ALE;
            nxt_ff.ale = ~ale_act_low_in;
            nxt_ff.ad = req_addr_in[15:0];
            nxt_ff.ad_oe = 16'hffff;
            nxt_ff.last_addr = req_addr_in;
            nxt_ff.addr_vld = 1'b1;
          end else begin
            nxt_ff.st = ppfm_pkg::PP_DATA;
            nxt_ff.ad = req_wdata_in;
            nxt_ff.ad_oe = req_wr_in ? 16'hffff : 16'h0000;
            nxt_ff.rd_n = req_wr_in; // [RULE9]
            nxt_ff.wr_n = ~req_wr_in; // [RULE10]
          end
        end
      end
      ppfm_pkg::PP_ALE: begin
        nxt_ff.ale = ale_act_low_in;
        nxt_ff.st = ppfm_pkg::PP_DATA;
        nxt_ff.ad = req_wdata_in;
        nxt_ff.ad_oe = req_wr_in ? 16'hffff : 16'h0000;
        nxt_ff.rd_n = req_wr_in; // [RULE9]
        nxt_ff.wr_n = ~req_wr_in; // [RULE10]
      end
      ppfm_pkg::PP_DATA: begin
        nxt_ff.rdata = mode16_in ? ad_in : {8'h00, ad_in[7:0]};
        nxt_ff.rd_n = 1'b1;
        nxt_ff.wr_n = 1'b1;
        nxt_ff.ack = 1'b1;
        nxt_ff.st = ppfm_pkg::PP_DONE;
      end
      ppfm_pkg::PP_DONE: begin
        nxt_ff.ad_oe = 16'h0000;
        if (!req_in) begin
          nxt_ff.st = ppfm_pkg::PP_IDLE;
        end
      end
    endcase
    if (pp_dis || any_flag) begin // [RULE11] [RULE5]
      nxt_ff.st = ppfm_pkg::PP_IDLE;
      nxt_ff.rd_n = 1'b1;
      nxt_ff.wr_n = 1'b1;
      nxt_ff.ale = ale_act_low_in;
      nxt_ff.ad_oe = 16'h0000;
      nxt_ff.addr_vld = 1'b0;
    end
    if (cur_ff.st == ppfm_pkg::PP_IDLE && nxt_ff.st == ppfm_pkg::PP_IDLE) begin
      nxt_ff.ale = ale_act_low_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      cur_ff <= '0;
      cur_ff.sc <= ppfm_pkg::SC_RST;
      cur_ff.st <= ppfm_pkg::PP_IDLE;
      cur_ff.rd_n <= 1'b1;
      cur_ff.wr_n <= 1'b1;
      cur_ff.ale <= ~ppfm_pkg::ALE_POL_RST;
    end else if (ce_in) begin
      cur_ff <= nxt_ff;
    end
  end

  // Pin mux fed from next state so pins line up with the strobes
  logic [15:0] ad_o_ff;
  logic [15:0] ad_oe_ff;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      ad_o_ff <= 16'h0000;
      ad_oe_ff <= 16'h0000;
    end else if (ce_in) begin
      ad_o_ff <= mux_o; // [RULE6] [RULE7]
      ad_oe_ff <= mux_oe;
    end
  end

  assign sc_out = cur_ff.sc;
  assign ad_out = ad_o_ff;
  assign ad_oe_out = ad_oe_ff;
  assign rd_n_out = cur_ff.rd_n;
  assign wr_n_out = cur_ff.wr_n;
  assign ale_out = cur_ff.ale;
  assign ack_out = cur_ff.ack;
  assign rdata_out = cur_ff.rdata;
  assign idp0_data_out = cur_ff.idp0;
  assign pflag_in_out = cur_ff.pflag_in;
  assign gflag_o_out = cur_ff.g_o;
  assign gflag_oe_out = cur_ff.g_oe;
  assign gflag_cond_out = cur_ff.g_cond;
  assign irq_out = cur_ff.irq;

  chk_sc_write_next: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE18]
    ce_in && sc_we_in |=> sc_out == $past(sc_wdata_in))
    else $error("Control word not applied next cycle");
  chk_strobes_flag_idle: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE11]
    ce_in && (sc_out[25:22] != 4'h0) |=> rd_n_out && wr_n_out)
    else $error("Strobe active while pins are flags");
  chk_port_disable: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE5]
    ce_in && sc_out[20] |=> cur_ff.ad_oe == 16'h0000 && wr_n_out)
    else $error("Port active while disabled");
  chk_rd_wr_excl: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE9]
    !(!rd_n_out && !wr_n_out))
    else $error("Read and write strobes both low");
  chk_ale_then_data: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE1]
    ce_in && cur_ff.st == ppfm_pkg::PP_ALE |=> (rd_n_out != wr_n_out))
    else $error("No data phase after address phase");
  chk_wr_drives_pins: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE10]
    !wr_n_out |-> cur_ff.ad_oe == 16'hffff)
    else $error("Write strobe without driven data");
  chk_irq_gate: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE16]
    ce_in && !sc_out[16] |=> !irq_out[0])
    else $error("Interrupt from disabled flag");
  chk_timer_pin: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [RULE17]
    ce_in && sc_out[19] |=> gflag_oe_out[3] && gflag_o_out[3] == $past(timer_exp_in))
    else $error("Timer output not on flag 3");
endmodule

// ### sim/ppfm_mem.sv
// Partner model: external address latch and a small asynchronous memory.
// Assumes the pins are resolved here; pull-ups hold undriven pins high.
`timescale 1ns/1ps
module ppfm_mem (
  input wire logic clk_sys_in,
  input wire logic ale_on_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic [15:0] ad_out_in,
  input wire logic [15:0] ad_oe_in,
  output logic [15:0] pin_out
);
  logic [15:0] lat_ff;
  logic [15:0] mem_ff [16];
  always_ff @(posedge clk_sys_in) begin
    if (ale_on_in) lat_ff <= pin_out;
    if (!wr_n_in) mem_ff[lat_ff[3:0]] <= pin_out;
  end
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (ad_oe_in[i]) pin_out[i] = ad_out_in[i];
      else if (!rd_n_in) pin_out[i] = mem_ff[lat_ff[3:0]][i];
      else pin_out[i] = 1'b1;
    end
  end
endmodule

// ### sim/parallel_port_flag_pin_mux_bench.sv
// Testbench: table of port accesses, then pin sharing cases.
// Assumes the latch and memory model on the address/data pins.
`timescale 1ns/1ps
module parallel_port_flag_pin_mux_bench;
  typedef struct packed {
    logic m16, wr, ale_e, ck;
    logic [23:0] a;
    logic [15:0] d;
  } ppfm_row_t;
  logic clk = 1'b0, rst = 1'b1, we = 1'b0, pol = 1'b0, m16 = 1'b1;
  logic req = 1'b0, wr = 1'b0, boot = 1'b0, tmr = 1'b0, bad;
  logic [31:0] sc_w = '0, sc;
  logic [23:0] addr = '0;
  logic [15:0] wd = '0, pfo = '0, pfoe = '0, pwm = '0, pin, ad_o, ad_oe;
  logic [15:0] rdata, pfin;
  logic [3:0] gin = '0, go = '0, goe = '0, sen = '0, ssn = 4'hf;
  logic [3:0] gfo, gfoe, gcond;
  logic [2:0] irq;
  logic rd_n, wr_n, ale, ack;
  int errors = 0, compares = 0;
  ppfm_row_t rows [9] = '{
    '{1, 1, 1, 0, 24'h000003, 16'h1234}, '{1, 1, 0, 0, 24'h000003, 16'habcd},
    '{1, 0, 0, 1, 24'h000003, 16'habcd}, '{1, 1, 1, 0, 24'h000005, 16'h5a5a},
    '{1, 0, 0, 1, 24'h010005, 16'h5a5a}, '{1, 0, 1, 1, 24'h000003, 16'habcd},
    '{0, 0, 1, 0, 24'h000103, 16'h0000}, '{0, 1, 0, 0, 24'h000145, 16'h0077},
    '{0, 0, 1, 1, 24'h010145, 16'h005a}};
  ppfm_top dut (.clk_sys_in(clk), .rst_in(rst), .ce_in(1'b1),
    .sc_we_in(we), .sc_wdata_in(sc_w), .ale_act_low_in(pol),
    .mode16_in(m16), .req_in(req), .req_wr_in(wr), .req_addr_in(addr),
    .req_wdata_in(wd), .ad_in(pin), .pflag_o_in(pfo), .pflag_oe_in(pfoe),
    .pwm_in(pwm), .gflag_in(gin), .gflag_o_in(go), .gflag_oe_in(goe),
    .spi_ss_en_in(sen), .spi_ss_n_in(ssn), .spi_boot_in(boot),
    .timer_exp_in(tmr), .sc_out(sc), .ad_out(ad_o), .ad_oe_out(ad_oe),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .ale_out(ale), .ack_out(ack),
    .rdata_out(rdata), .idp0_data_out(), .pflag_in_out(pfin),
    .gflag_o_out(gfo), .gflag_oe_out(gfoe), .gflag_cond_out(gcond),
    .irq_out(irq));
  ppfm_mem mem (.clk_sys_in(clk), .ale_on_in(ale ^ pol), .rd_n_in(rd_n),
    .wr_n_in(wr_n), .ad_out_in(ad_o), .ad_oe_in(ad_oe), .pin_out(pin));
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic access(input ppfm_row_t r);
    int n, na, ns;
    @(posedge clk);
    m16 <= r.m16; wr <= r.wr; addr <= r.a; wd <= r.d; req <= 1'b1;
    n = 0; na = 0; ns = 0;
    while (ack !== 1'b1 && n < 8) begin
      @(posedge clk); #1;
      n++;
      na += ((ale ^ pol) === 1'b1);
      ns += (rd_n === 1'b0) + 2 * (wr_n === 1'b0);
    end
    @(posedge clk);
    req <= 1'b0;
    chk(n, r.ale_e ? 3 : 2);
    chk(na, {31'h0, r.ale_e});
    chk(ns, r.wr ? 2 : 1);
    if (r.ck) chk(rdata, r.d);
  endtask
  task automatic wsc(input logic [31:0] v);
    @(posedge clk);
    we <= 1'b1; sc_w <= v;
    @(posedge clk);
    we <= 1'b0;
    #1 chk(sc, v);
    repeat (2) @(posedge clk);
    #1;
  endtask
  initial begin
    #(25ns * 3000);
    errors++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge clk);
    #1 chk({rd_n, wr_n, ale, ack, ad_oe}, {4'b1100, 16'h0});
    chk(sc, 32'h0);
    @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) access(rows[i]);
    @(posedge clk);
    pol <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(ale, 1'b1);
    access('{1, 0, 1, 0, 24'h000009, 16'h0});
    pfo <= 16'h00a5; pfoe <= 16'h000f; pwm <= 16'h0060;
    wsc(32'h0850_0000);
    chk({ad_oe[7:0], ad_o[7:0], pfin[7:0]}, 24'hff6565);
    @(posedge clk);
    req <= 1'b1;
    bad = 1'b0;
    repeat (8) begin
      @(posedge clk); #1;
      bad |= ack | !rd_n | !wr_n | (ale ^ pol);
    end
    chk(bad, 1'b0);
    @(posedge clk);
    req <= 1'b0; gin <= 4'b0101; tmr <= 1'b1;
    wsc(32'h000f_0000);
    chk({irq, gfoe[3], gfo[3], gcond}, {3'b101, 2'b11, 4'h5});
    boot <= 1'b1; ssn <= 4'h0; sen <= 4'b0010; goe <= 4'b0100; go <= 4'h4;
    wsc(32'h0);
    chk({gfoe[2:0], gfo[2:0]}, 6'b111100);
    wrap_up();
  end
endmodule
